// ===== verilog/fcab_pkg.sv
// fcab_pkg: constants, register map and carrier types of the fabric csr access bridge.
// assumes a 32-bit apb host port and a single-cycle-per-word fabric csr target on pclk.
// Operation
// - four-bit byte-lane select, zero at reset
// - lane bit n governs data byte n
// - sixteen-bit target index, zero at reset
// - upper pause address: bits 47:32, ones
// - lower pause address: full 32 bits RW
// - pause frames use the 48-bit address
// - loader fills upper from bytes 05h, 06h
// - loader fills lower from bytes 01h..04h
// - loaded bytes also go to host address
// - host may overwrite after initialization
// - write-only window 200h..2dch, data resets zero
// - window write loads index, lanes, write, busy
// - busy clears when window write completes
// - window reads unsupported; use indirect path
// - window offset maps through fixed index table
// - busy launches operation, self-clears when done
// - direction zero writes, one reads
package fcab_pkg;
   // ----------------------------------------------------------------
   // register byte addresses
   // ----------------------------------------------------------------
   localparam logic [11:0] FCAB_CMD_OFF = 12'h1b0;
   localparam logic [11:0] FCAB_IDATA_OFF = 12'h1b4;
   localparam logic [11:0] FCAB_PSA_HI_OFF = 12'h1f0;
   localparam logic [11:0] FCAB_PSA_LO_OFF = 12'h1f4;
   localparam logic [11:0] FCAB_WIN_FIRST = 12'h200;
   localparam logic [11:0] FCAB_WIN_LAST = 12'h2dc;
   // ----------------------------------------------------------------
   // command register fields
   // ----------------------------------------------------------------
   localparam int FCAB_CMD_PEND_BIT = 31;
   localparam int FCAB_CMD_DIR_BIT = 30;
   localparam int FCAB_CMD_INC_BIT = 29;
   localparam int FCAB_CMD_DEC_BIT = 28;
   localparam int FCAB_CMD_BE_LSB = 16;
   localparam logic [3:0] FCAB_BE_RST = 4'h0;
   localparam logic [3:0] FCAB_BE_ALL = 4'hf;
   localparam logic [15:0] FCAB_INDEX_RST = 16'h0000;
   localparam logic FCAB_DIR_WRITE = 1'b0;
   localparam logic FCAB_DIR_READ = 1'b1;
   // ----------------------------------------------------------------
   // reset values and loader byte locations
   // ----------------------------------------------------------------
   localparam logic [15:0] FCAB_PSA_HI_RST = 16'hffff;
   // arbitrary neutral value
   localparam logic [31:0] FCAB_PSA_LO_RST = 32'h0000_0000;
   localparam logic [31:0] FCAB_WIN_DATA_RST = 32'h0000_0000;
   localparam logic [7:0] FCAB_EE_LO_B0 = 8'h01;
   localparam logic [7:0] FCAB_EE_LO_B3 = 8'h04;
   localparam logic [7:0] FCAB_EE_HI_B0 = 8'h05;
   localparam logic [7:0] FCAB_EE_HI_B1 = 8'h06;
   // ----------------------------------------------------------------
   // types
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      FCAB_IDLE = 2'b01,
      FCAB_WAIT = 2'b10
   } fcab_state_t;
   typedef struct packed {
      logic req;
      logic write;
      logic [15:0] index;
      logic [3:0] lanes;
      logic [31:0] wdata;
   } fcab_fab_req_t;
   typedef struct packed {
      logic valid;
      logic [7:0] addr;
      logic [7:0] data;
   } fcab_ee_byte_t;
endpackage

// ===== verilog/fcab_bridge.sv
// fcab_bridge: apb slave giving the host indirect and direct-window access to fabric csrs,
// plus the pause-frame source address preset by the eeprom loader.
// assumes fabric and loader logic run on pclk; fabric pulses ack once per held request.
`timescale 1ns/1ps
module fcab_bridge
   import fcab_pkg::*;
(
   // clock, reset, enable
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // fabric csr side
   output fcab_fab_req_t fab_req,
   input wire logic fab_ack,
   input wire logic [31:0] fab_rdata,
   // eeprom loader byte stream
   input fcab_ee_byte_t ee_byte,
   // address consumers
   output logic [47:0] pause_src_addr,
   output logic [15:0] host_station_addr_upper,
   output logic [31:0] host_station_addr_lower,
   output logic host_station_addr_load
);

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   // one struct holds all state, so a single flop process and one reset cover it
   typedef struct packed {
      fcab_state_t st;
      logic fabric_op_pending;
      logic fabric_direction;
      logic index_step_up;
      logic index_step_down;
      logic [3:0] fabric_byte_lane_select;
      logic [15:0] fabric_target_index;
      logic [31:0] fabric_indirect_data;
      // kept on record only: the window cannot be read back
      logic [31:0] direct_write_value;
      logic [15:0] psa_hi;
      logic [31:0] psa_lo;
      logic [15:0] hsa_hi;
      logic [31:0] hsa_lo;
      logic hsa_load;
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
      fcab_fab_req_t fab;
   } fcab_regs_t;

   fcab_regs_t s_r;
   fcab_regs_t s_nxt;

   // ----------------------------------------------------------------
   // host register decode
   // ----------------------------------------------------------------
   // one-hot select of the plain registers; write strobes and read mux share it,
   // so an offset can never be writable under one name and readable under another
   typedef struct packed {
      logic cmd;
      logic idata;
      logic psa_hi;
      logic psa_lo;
   } fcab_reg_sel_t;

   function automatic fcab_reg_sel_t fcab_reg_decode(input logic [11:0] a);
      fcab_reg_sel_t r;
      r.cmd = a == FCAB_CMD_OFF;
      r.idata = a == FCAB_IDATA_OFF;
      r.psa_hi = a == FCAB_PSA_HI_OFF;
      r.psa_lo = a == FCAB_PSA_LO_OFF;
      return r;
   endfunction

   // host view of the command register; bits 27:20 are reserved and read as zero
   function automatic logic [31:0] fcab_cmd_word(input fcab_regs_t s);
      logic [31:0] w;
      w = 32'h0000_0000;
      w[FCAB_CMD_PEND_BIT] = s.fabric_op_pending;
      w[FCAB_CMD_DIR_BIT] = s.fabric_direction;
      w[FCAB_CMD_INC_BIT] = s.index_step_up;
      w[FCAB_CMD_DEC_BIT] = s.index_step_down;
      w[FCAB_CMD_BE_LSB +: 4] = s.fabric_byte_lane_select;
      w[15:0] = s.fabric_target_index;
      return w;
   endfunction

   // ----------------------------------------------------------------
   // direct window translation
   // ----------------------------------------------------------------
   // returns {hit, index}; every aligned slot is mapped today, but the hit bit
   // keeps holes safe if the table ever grows sparse
   function automatic logic [16:0] fcab_win_map(input logic [11:0] a);
      logic [5:0] slot;
      logic [16:0] r;
      slot = 6'((a - FCAB_WIN_FIRST) >> 2);
      r = {1'b1, 16'h0000};
      if (a < FCAB_WIN_FIRST || a > FCAB_WIN_LAST || a[1:0] != 2'b00) begin
         r = 17'h00000;
      end else begin
         unique case (slot)
            6'h00: r[15:0] = 16'h0001;
            6'h01: r[15:0] = 16'h0004;
            6'h02: r[15:0] = 16'h0401;
            6'h03: r[15:0] = 16'h0440;
            6'h04: r[15:0] = 16'h0441;
            6'h05: r[15:0] = 16'h0480;
            6'h06: r[15:0] = 16'h0801;
            6'h07: r[15:0] = 16'h0840;
            6'h08: r[15:0] = 16'h0841;
            6'h09: r[15:0] = 16'h0880;
            6'h0a: r[15:0] = 16'h0c01;
            6'h0b: r[15:0] = 16'h0c40;
            6'h0c: r[15:0] = 16'h0c41;
            6'h0d: r[15:0] = 16'h0c80;
            6'h0e: r[15:0] = 16'h1800;
            6'h0f: r[15:0] = 16'h1801;
            6'h10: r[15:0] = 16'h1802;
            6'h11: r[15:0] = 16'h1809;
            6'h12: r[15:0] = 16'h180b;
            6'h13: r[15:0] = 16'h180c;
            6'h14: r[15:0] = 16'h1811;
            6'h15: r[15:0] = 16'h1812;
            6'h16: r[15:0] = 16'h1840;
            6'h17: r[15:0] = 16'h1841;
            6'h18: r[15:0] = 16'h1842;
            6'h19: r[15:0] = 16'h1843;
            6'h1a: r[15:0] = 16'h1845;
            6'h1b: r[15:0] = 16'h1846;
            6'h1c: r[15:0] = 16'h1847;
            6'h1d: r[15:0] = 16'h1848;
            6'h1e: r[15:0] = 16'h1849;
            6'h1f: r[15:0] = 16'h184a;
            6'h20: r[15:0] = 16'h184b;
            6'h21: r[15:0] = 16'h184d;
            6'h22: r[15:0] = 16'h1855;
            6'h23: r[15:0] = 16'h1856;
            6'h24: r[15:0] = 16'h1857;
            6'h25: r[15:0] = 16'h1880;
            6'h26: r[15:0] = 16'h1c00;
            6'h27: r[15:0] = 16'h1c01;
            6'h28: r[15:0] = 16'h1c02;
            6'h29: r[15:0] = 16'h1c03;
            6'h2a: r[15:0] = 16'h1c04;
            6'h2b: r[15:0] = 16'h1c09;
            6'h2c: r[15:0] = 16'h1c0a;
            6'h2d: r[15:0] = 16'h1c0c;
            6'h2e: r[15:0] = 16'h1c0d;
            6'h2f: r[15:0] = 16'h1c0e;
            6'h30: r[15:0] = 16'h1c0f;
            6'h31: r[15:0] = 16'h1c10;
            6'h32: r[15:0] = 16'h1c11;
            6'h33: r[15:0] = 16'h1c12;
            6'h34: r[15:0] = 16'h1c13;
            6'h35: r[15:0] = 16'h1c14;
            6'h36: r[15:0] = 16'h1c15;
            6'h37: r[15:0] = 16'h1c20;
            default: r = 17'h00000;
         endcase
      end
      return r;
   endfunction

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   logic setup;
   logic access;
   logic wr_cmd;
   logic wr_idata;
   logic wr_hi;
   logic wr_lo;
   fcab_reg_sel_t sel;
   logic [16:0] win;
   logic rd_known;
   logic [31:0] rd_val;

   always_comb begin
      s_nxt = s_r;
      setup = psel && !penable;
      access = psel && penable && s_r.pready;
      win = fcab_win_map(paddr);
      sel = fcab_reg_decode(paddr);
      // writes to the command path are dropped while an operation is in flight
      wr_cmd = access && pwrite && sel.cmd && !s_r.fabric_op_pending;
      wr_idata = access && pwrite && sel.idata && !s_r.fabric_op_pending;
      wr_hi = access && pwrite && sel.psa_hi;
      wr_lo = access && pwrite && sel.psa_lo;
      rd_known = 1'b1;
      rd_val = 32'h0000_0000;

      // apb answer: one wait-free access phase after each setup
      // pready comes from a flop, so every access costs one fixed cycle but no path is long
      s_nxt.pready = setup;
      s_nxt.pslverr = 1'b0;
      s_nxt.prdata = 32'h0000_0000;
      s_nxt.hsa_load = 1'b0;
      if (sel.cmd) begin
         rd_val = fcab_cmd_word(s_r);
      end else if (sel.idata) begin
         rd_val = s_r.fabric_indirect_data;
      end else if (sel.psa_hi) begin
         rd_val = {16'h0000, s_r.psa_hi};
      end else if (sel.psa_lo) begin
         rd_val = s_r.psa_lo;
      end else begin
         rd_known = 1'b0;
      end
      if (setup) begin
         s_nxt.prdata = pwrite ? 32'h0000_0000 : rd_val;
         // window reads and unmapped addresses answer with an error
         s_nxt.pslverr = pwrite ? !(rd_known || win[16]) : !rd_known;
      end

      // pause source address: host writes, then loader bytes on top
      // the loader byte wins a same-cycle clash; the other bytes of the register keep the host value
      if (wr_hi) begin
         s_nxt.psa_hi = pwdata[15:0];
      end
      if (wr_lo) begin
         s_nxt.psa_lo = pwdata;
      end
      if (ee_byte.valid) begin
         if (ee_byte.addr >= FCAB_EE_LO_B0 && ee_byte.addr <= FCAB_EE_LO_B3) begin
            s_nxt.psa_lo[8 * 2'(ee_byte.addr - FCAB_EE_LO_B0) +: 8] = ee_byte.data;
            s_nxt.hsa_lo[8 * 2'(ee_byte.addr - FCAB_EE_LO_B0) +: 8] = ee_byte.data;
            s_nxt.hsa_load = 1'b1;
         end else if (ee_byte.addr == FCAB_EE_HI_B0) begin
            s_nxt.psa_hi[7:0] = ee_byte.data;
            s_nxt.hsa_hi[7:0] = ee_byte.data;
            s_nxt.hsa_load = 1'b1;
         end else if (ee_byte.addr == FCAB_EE_HI_B1) begin
            s_nxt.psa_hi[15:8] = ee_byte.data;
            s_nxt.hsa_hi[15:8] = ee_byte.data;
            s_nxt.hsa_load = 1'b1;
         end
      end

      if (wr_idata) begin
         s_nxt.fabric_indirect_data = pwdata;
      end

      unique case (s_r.st)
         FCAB_IDLE: begin
            if (wr_cmd) begin
               s_nxt.fabric_op_pending = pwdata[FCAB_CMD_PEND_BIT];
               s_nxt.fabric_direction = pwdata[FCAB_CMD_DIR_BIT];
               s_nxt.index_step_up = pwdata[FCAB_CMD_INC_BIT];
               s_nxt.index_step_down = pwdata[FCAB_CMD_DEC_BIT];
               s_nxt.fabric_byte_lane_select = pwdata[FCAB_CMD_BE_LSB +: 4];
               s_nxt.fabric_target_index = pwdata[15:0];
               if (pwdata[FCAB_CMD_PEND_BIT]) begin
                  s_nxt.st = FCAB_WAIT;
                  s_nxt.fab.req = 1'b1;
                  s_nxt.fab.write = pwdata[FCAB_CMD_DIR_BIT] == FCAB_DIR_WRITE;
                  s_nxt.fab.index = pwdata[15:0];
                  s_nxt.fab.lanes = pwdata[FCAB_CMD_BE_LSB +: 4];
                  s_nxt.fab.wdata = s_r.fabric_indirect_data;
               end
            // the window reuses the command path, so the command register shows what ran;
            // a window write while busy breaks the host's wait and is dropped, not queued
            end else if (access && pwrite && win[16] && !s_r.fabric_op_pending) begin
               s_nxt.direct_write_value = pwdata;
               s_nxt.fabric_target_index = win[15:0];
               s_nxt.fabric_byte_lane_select = FCAB_BE_ALL;
               s_nxt.fabric_direction = FCAB_DIR_WRITE;
               s_nxt.fabric_op_pending = 1'b1;
               s_nxt.st = FCAB_WAIT;
               s_nxt.fab.req = 1'b1;
               s_nxt.fab.write = 1'b1;
               s_nxt.fab.index = win[15:0];
               s_nxt.fab.lanes = FCAB_BE_ALL;
               s_nxt.fab.wdata = pwdata;
            end
         end
         FCAB_WAIT: begin
            // every request field holds until the ack, so a slow fabric may sample late
            if (fab_ack) begin
               s_nxt.st = FCAB_IDLE;
               s_nxt.fab.req = 1'b0;
               s_nxt.fabric_op_pending = 1'b0;
               // read data is taken on the ack edge only; the fabric may drive junk otherwise
               if (!s_r.fab.write) begin
                  s_nxt.fabric_indirect_data = fab_rdata;
               end
            end
         end
      endcase
      // a window offset with no table entry matches neither launch branch, so it
      // leaves the command register and the fabric untouched
   end

   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   // ce low freezes everything, apb answer included, so a stalled bus loses no pready
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_r.st <= FCAB_IDLE;
         s_r.fabric_op_pending <= 1'b0;
         s_r.fabric_direction <= FCAB_DIR_WRITE;
         s_r.index_step_up <= 1'b0;
         s_r.index_step_down <= 1'b0;
         s_r.fabric_byte_lane_select <= FCAB_BE_RST;
         s_r.fabric_target_index <= FCAB_INDEX_RST;
         s_r.fabric_indirect_data <= 32'h0000_0000;
         s_r.direct_write_value <= FCAB_WIN_DATA_RST;
         s_r.psa_hi <= FCAB_PSA_HI_RST;
         s_r.psa_lo <= FCAB_PSA_LO_RST;
         s_r.hsa_hi <= FCAB_PSA_HI_RST;
         s_r.hsa_lo <= FCAB_PSA_LO_RST;
         s_r.hsa_load <= 1'b0;
         s_r.prdata <= 32'h0000_0000;
         s_r.pready <= 1'b0;
         s_r.pslverr <= 1'b0;
         s_r.fab <= '0;
      end else if (ce) begin
         s_r <= s_nxt;
      end
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   // plain copies of state flops; no decode sits between a flop and its pin
   assign prdata = s_r.prdata;
   assign pready = s_r.pready;
   assign pslverr = s_r.pslverr;
   assign fab_req = s_r.fab;
   assign pause_src_addr = {s_r.psa_hi, s_r.psa_lo};
   assign host_station_addr_upper = s_r.hsa_hi;
   assign host_station_addr_lower = s_r.hsa_lo;
   assign host_station_addr_load = s_r.hsa_load;

endmodule // fcab_bridge

// ===== verif/fcab_bridge_checker_assertions.sv
// fcab_bridge_checker: port-level properties of fcab_bridge.
// assumes ce held high by the bench and a fabric that acks once per request.
`timescale 1ns/1ps
module fcab_bridge_checker
   import fcab_pkg::*;
(
   // clock, reset
   input wire logic pclk,
   input wire logic presetn,
   // apb
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic pready,
   input wire logic pslverr,
   // fabric and loader
   input wire fcab_fab_req_t fab_req,
   input wire logic fab_ack,
   input wire fcab_ee_byte_t ee_byte,
   input wire logic [47:0] pause_src_addr,
   input wire logic [31:0] host_station_addr_lower,
   input wire logic host_station_addr_load
);
   logic wacc;
   logic in_win;
   assign wacc = psel && penable && pready && pwrite;
   assign in_win = paddr >= FCAB_WIN_FIRST && paddr <= FCAB_WIN_LAST;
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence win_wr_s;
      wacc && in_win && paddr[1:0] == 2'b00 && !fab_req.req;
   endsequence
   sequence launched_s;
      fab_req.req && fab_req.write && fab_req.lanes == FCAB_BE_ALL;
   endsequence
   win_launch_a: assert property (win_wr_s |=> launched_s ##0 fab_req.wdata == $past(pwdata))
      else $error("window write did not launch");
   win_index_a: assert property (win_wr_s ##0 paddr == 12'h228 |=> fab_req.index == 16'h0c01)
      else $error("window index wrong");
   req_hold_a: assert property (fab_req.req && !fab_ack |=> $stable(fab_req))
      else $error("request moved before ack");
   ack_clear_a: assert property (fab_ack |=> !fab_req.req)
      else $error("request stayed after ack");
   win_read_a: assert property (psel && penable && pready && !pwrite && in_win |-> pslverr)
      else $error("window read not refused");
   bad_off_a: assert property (wacc && in_win && paddr[1:0] != 2'b00 && !fab_req.req |=> !fab_req.req)
      else $error("misaligned window write launched");
   lo_load_a: assert property (ee_byte.valid && ee_byte.addr == 8'h01 |=>
      pause_src_addr[7:0] == $past(ee_byte.data) && host_station_addr_lower[7:0] == $past(ee_byte.data))
      else $error("low byte not loaded");
   hi_load_a: assert property (ee_byte.valid && ee_byte.addr == 8'h06 |=>
      pause_src_addr[47:40] == $past(ee_byte.data))
      else $error("upper byte not loaded");
   copy_pulse_a: assert property (ee_byte.valid && ee_byte.addr inside {[8'h01:8'h06]} |-> ##[1:2]
      host_station_addr_load)
      else $error("host copy pulse missing");
endmodule // fcab_bridge_checker

bind fcab_bridge fcab_bridge_checker u_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .fab_req(fab_req),
   .fab_ack(fab_ack), .ee_byte(ee_byte), .pause_src_addr(pause_src_addr),
   .host_station_addr_lower(host_station_addr_lower), .host_station_addr_load(host_station_addr_load));

// ===== verif/fcab_fabric_model.sv
// fcab_fabric_model: behavioural fabric csr target behind the bridge.
// assumes one request held until ack; lat sets the answer delay.
`timescale 1ns/1ps
module fcab_fabric_model
   import fcab_pkg::*;
(
   // clock, reset
   input wire logic pclk,
   input wire logic presetn,
   // answer delay in cycles
   input wire logic [3:0] lat,
   // fabric port
   input wire fcab_fab_req_t fab_req,
   output logic fab_ack,
   output logic [31:0] fab_rdata
);
   logic [31:0] mem [0:65535];
   logic [3:0] cnt;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fab_ack <= 1'b0;
         cnt <= 4'h0;
         fab_rdata <= 32'h0;
      end else begin
         fab_ack <= 1'b0;
         // data only valid with ack, so keep it moving otherwise
         fab_rdata <= ~fab_rdata;
         if (fab_req.req && !fab_ack && cnt == lat) begin
            fab_ack <= 1'b1;
            cnt <= 4'h0;
            fab_rdata <= mem[fab_req.index];
            // unselected lanes keep their old byte
            for (int b = 0; b < 4; b++) begin
               if (fab_req.write && fab_req.lanes[b]) begin
                  mem[fab_req.index][8*b +: 8] <= fab_req.wdata[8*b +: 8];
               end
            end
         end else if (fab_req.req && !fab_ack) begin
            cnt <= cnt + 4'h1;
         end
      end
   end
endmodule // fcab_fabric_model

// ===== verif/fabric_csr_access_bridge_tb_top.sv
// fabric_csr_access_bridge_tb_top: apb-driven tests of fcab_bridge with a fabric model.
// assumes ce always high; the loader stream is driven here.
`timescale 1ns/1ps
module fabric_csr_access_bridge_tb_top import fcab_pkg::*;;
   localparam logic [11:0] WOFF [4] = '{12'h200, 12'h208, 12'h228, 12'h2dc};
   localparam logic [15:0] WIDX [4] = '{16'h0001, 16'h0401, 16'h0c01, 16'h1c20};
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, fab_ack, hs_load, err;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, fab_rdata, rd, hs_lo, cur, wd;
   logic [15:0] hs_hi;
   logic [47:0] psa;
   logic [3:0] lat, ln;
   fcab_fab_req_t fab_req;
   fcab_ee_byte_t ee_byte;
   int n_errors, comparisons;
   fcab_bridge u_dut (.pclk(pclk), .presetn(presetn), .ce(1'b1), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .fab_req(fab_req), .fab_ack(fab_ack), .fab_rdata(fab_rdata), .ee_byte(ee_byte), .pause_src_addr(psa),
      .host_station_addr_upper(hs_hi), .host_station_addr_lower(hs_lo), .host_station_addr_load(hs_load));
   fcab_fabric_model u_fab (.pclk(pclk), .presetn(presetn), .lat(lat), .fab_req(fab_req),
      .fab_ack(fab_ack), .fab_rdata(fab_rdata));
   // ----
   // tasks
   // ----
   task automatic tally_and_finish();
      if (n_errors == 0 && comparisons > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   task automatic chk(input logic [47:0] got, input logic [47:0] exp);
      comparisons++;
      if (got !== exp) begin
         n_errors++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 16);
      if (pready !== 1'b1) begin
         n_errors++;
         tally_and_finish();
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // polls the busy flag; rd holds the last command word
   task automatic idle();
      int n;
      n = 0;
      rd = 32'hffff_ffff;
      while (rd[FCAB_CMD_PEND_BIT] !== 1'b0 && n < 40) begin
         apb(1'b0, FCAB_CMD_OFF, 32'h0);
         n++;
      end
      if (rd[FCAB_CMD_PEND_BIT] !== 1'b0) begin
         n_errors++;
         tally_and_finish();
      end
   endtask
   initial begin
      pclk = 1'b0;
      forever #12.5 pclk = ~pclk;
   end
   initial begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h0;
      pwdata = 32'h0;
      ee_byte = '0;
      lat = 4'h0;
      n_errors = 0;
      comparisons = 0;
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, FCAB_PSA_HI_OFF, 32'h0);
      chk(rd, 32'h0000_ffff);
      apb(1'b0, FCAB_CMD_OFF, 32'h0);
      chk(rd, 32'h0);
      chk(psa, {FCAB_PSA_HI_RST, FCAB_PSA_LO_RST});
      apb(1'b1, FCAB_PSA_HI_OFF, 32'habcd_1234);
      apb(1'b1, FCAB_PSA_LO_OFF, 32'h89ab_cdef);
      chk(err, 1'b0);
      apb(1'b0, FCAB_PSA_HI_OFF, 32'h0);
      chk(rd, 32'h0000_1234);
      apb(1'b0, FCAB_PSA_LO_OFF, 32'h0);
      chk(rd, 32'h89ab_cdef);
      chk(psa, 48'h1234_89ab_cdef);
      for (int b = 1; b <= 6; b++) begin
         @(posedge pclk);
         ee_byte <= '{1'b1, 8'(b), 8'(b + 16)};
      end
      @(posedge pclk);
      ee_byte <= '0;
      // the last byte is taken at the edge above; its copy pulse stands one cycle only
      @(posedge pclk);
      chk(hs_load, 1'b1);
      repeat (2) @(posedge pclk);
      chk(hs_load, 1'b0);
      chk(psa, 48'h1615_1413_1211);
      chk({hs_hi, hs_lo}, 48'h1615_1413_1211);
      // slow fabric so the busy flag is still visible
      lat <= 4'h9;
      for (int i = 0; i < 4; i++) begin
         apb(1'b1, WOFF[i], {WIDX[i], ~WIDX[i]});
         chk(err, 1'b0);
         apb(1'b0, FCAB_CMD_OFF, 32'h0);
         chk(rd, {16'h800f, WIDX[i]});
         idle();
         chk(rd, {16'h000f, WIDX[i]});
         apb(1'b1, FCAB_CMD_OFF, {16'hc00f, WIDX[i]});
         idle();
         apb(1'b0, FCAB_IDATA_OFF, 32'h0);
         chk(rd, {WIDX[i], ~WIDX[i]});
      end
      lat <= 4'h0;
      cur = 32'h0401_fbfe;
      for (int p = 0; p < 2; p++) begin
         ln = p ? 4'ha : 4'h5;
         wd = p ? 32'h3c3c_3c3c : 32'ha5a5_a5a5;
         for (int b = 0; b < 4; b++)
            if (ln[b]) cur[8*b +: 8] = wd[8*b +: 8];
         apb(1'b1, FCAB_IDATA_OFF, wd);
         apb(1'b1, FCAB_CMD_OFF, {12'h800, ln, 16'h0401});
         idle();
         apb(1'b1, FCAB_CMD_OFF, 32'hc00f_0401);
         idle();
         apb(1'b0, FCAB_IDATA_OFF, 32'h0);
         chk(rd, cur);
      end
      apb(1'b0, 12'h204, 32'h0);
      chk(err, 1'b1);
      apb(1'b1, 12'h202, 32'h1234_5678);
      chk(err, 1'b1);
      apb(1'b0, FCAB_CMD_OFF, 32'h0);
      chk(rd, 32'h400f_0401);
      tally_and_finish();
   end
endmodule // fabric_csr_access_bridge_tb_top
